/* File: hdl/int_ctrl_pkg.sv */
// shared constants for the interrupt enable and request register block
package int_ctrl_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned    IDX_EDGE_SEL  = 2;
  localparam int unsigned    IDX_EN_FIRST  = 3;
  localparam int unsigned    IDX_EN_SECOND = 4;
  localparam int unsigned    IDX_REQ_FIRST = 6;
  localparam int unsigned    ADDR_W        = 5;
  localparam logic [4:0]     ADDR_EDGE_SEL  = 5'h08;
  localparam logic [4:0]     ADDR_EN_FIRST  = 5'h0c;
  localparam logic [4:0]     ADDR_EN_SECOND = 5'h10;
  localparam logic [4:0]     ADDR_REQ_FIRST = 5'h18;

  // edge select register fields
  localparam int unsigned    BIT_PIN0_EDGE = 0;
  localparam int unsigned    BIT_PIN1_EDGE = 1;
  localparam logic [7:0]     EDGE_SEL_ONES = 8'he0;
  localparam logic [1:0]     EDGE_SEL_RST  = 2'h0;

  // first enable register fields
  localparam int unsigned    BIT_TIMER_A_EN   = 7;
  localparam int unsigned    BIT_WAKEUP_EN    = 5;
  localparam int unsigned    BIT_EVENT_PIN_EN = 2;
  localparam int unsigned    BIT_PIN1_EN      = 1;
  localparam int unsigned    BIT_PIN0_EN      = 0;
  localparam logic [7:0]     EN_FIRST_IMPL    = 8'ha7;

  // second enable register fields
  localparam int unsigned    BIT_DT_EN       = 7;
  localparam int unsigned    BIT_ADC_EN      = 6;
  localparam int unsigned    BIT_TFH_EN      = 3;
  localparam int unsigned    BIT_TFL_EN      = 2;
  localparam int unsigned    BIT_EC_EN       = 0;
  localparam logic [7:0]     EN_SECOND_IMPL  = 8'hcd;
  localparam logic [7:0]     EN_RST          = 8'h00;

  // first request register fields
  localparam int unsigned    BIT_TIMER_A_REQ   = 7;
  localparam int unsigned    BIT_FIXED_ONE     = 5;
  localparam int unsigned    BIT_EVENT_PIN_REQ = 2;
  localparam int unsigned    BIT_PIN1_REQ      = 1;
  localparam int unsigned    BIT_PIN0_REQ      = 0;
  localparam logic [7:0]     REQ_FIXED_ONES    = 8'h20;
  localparam logic [3:0]     REQ_RST           = 4'h0;

endpackage

/* File: hdl/interrupt_enable_request_regs.sv */
// interrupt edge select, enable and first request registers behind an avalon-mm slave
// How it works
// - pin 0 edge select: 0 falling (reset), 1 rising.
// - first enable bit 7 gates timer A overflow requests.
// - first enable bit 5 gates all eight wakeup pin requests.
// - first enable bit 2 gates event-counter pin requests.
// - first enable bits 1 and 0 gate external pins 1 and 0.
// - second enable bit 7 gates direct-transfer requests.
// - second enable bit 6 gates converter requests.
// - second enable bit 3 gates timer FH match and overflow.
// - second enable bit 2 gates timer FL match and overflow.
// - second enable bit 0 gates asynchronous event counter requests.
// - every implemented enable bit reads 0 after reset.
// - request flags stay set on acceptance; software clears with 0.
// - writing 1 to a flag does nothing; 0 clears it.
// - timer A wrap from ff to 00 sets bit 7 flag.
// - request register bit 5 always reads 1.
// - event pin flag sets on selected edge when in interrupt mode.
// - pin 1 and 0 flags set on selected edge in interrupt mode.
// - with global mask set flags still set, nothing accepted.
// - pin 1 edge select: 0 falling (reset), 1 rising.
`timescale 1ns/1ps
module interrupt_enable_request_regs
  import int_ctrl_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              ext_int_pin_zero,
  input  wire logic              ext_int_pin_one,
  input  wire logic              event_counter_int_pin,
  input  wire logic              ext_pin0_int_mode,
  input  wire logic              ext_pin1_int_mode,
  input  wire logic              event_pin_int_mode,
  input  wire logic              event_pin_edge_sel,
  input  wire logic              timer_a_wrap,
  input  wire logic              wakeup_pins_req,
  input  wire logic              direct_transfer_req,
  input  wire logic              adc_req,
  input  wire logic              timer_fh_req,
  input  wire logic              timer_fl_req,
  input  wire logic              event_counter_req,
  input  wire logic              condition_code_mask,
  output logic                   timer_a_irq,
  output logic                   wakeup_irq,
  output logic                   event_pin_irq,
  output logic                   ext_pin1_irq,
  output logic                   ext_pin0_irq,
  output logic                   direct_transfer_irq,
  output logic                   adc_irq,
  output logic                   timer_fh_irq,
  output logic                   timer_fl_irq,
  output logic                   event_counter_irq,
  output logic                   cpu_int_req
);

  // selected edge: rising when sel is 1, falling when 0
  function automatic logic edge_hit(input logic cur, input logic prev, input logic sel);
    edge_hit = sel ? (cur & ~prev) : (~cur & prev);
  endfunction

  // pin synchronisers: stage 1 feeds only stage 2; stage 3 holds the previous level
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_prev_q;
  wire  [2:0] pin_raw = {event_counter_int_pin, ext_int_pin_one, ext_int_pin_zero};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1_q   <= 3'h7;
      pin_s2_q   <= 3'h7;
      pin_prev_q <= 3'h7;
    end else begin
      pin_s1_q   <= pin_raw;
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  // bus handshake: one wait cycle, then the access completes
  logic              wait_q;
  logic [31:0]       rdata_q;
  wire               req      = read | write;
  wire               done     = req & ~wait_q;
  wire               wr_done  = write & done;
  wire               hit_edge = address == ADDR_EDGE_SEL;
  wire               hit_en1  = address == ADDR_EN_FIRST;
  wire               hit_en2  = address == ADDR_EN_SECOND;
  wire               hit_req  = address == ADDR_REQ_FIRST;
  wire  [7:0]        wbyte    = writedata[7:0];

  // control registers
  logic [1:0] edge_sel_q;
  logic [7:0] en1_q;
  logic [7:0] en2_q;
  logic [3:0] flag_q;
  logic [1:0] edge_sel_d;
  logic [7:0] en1_d;
  logic [7:0] en2_d;
  logic [3:0] flag_d;

  // reserved bits are not stored, so a stray 1 there reads back 0, except edge select bits 7:5, which read 1
  assign edge_sel_d = (wr_done & hit_edge) ? wbyte[1:0] : edge_sel_q;
  assign en1_d      = (wr_done & hit_en1) ? (wbyte & EN_FIRST_IMPL) : en1_q;
  assign en2_d      = (wr_done & hit_en2) ? (wbyte & EN_SECOND_IMPL) : en2_q;

  // flag order inside flag_q: 3 timer A, 2 event pin, 1 pin 1, 0 pin 0
  wire  [3:0] set_ev;
  wire  [3:0] clr_ev;
  assign set_ev[3] = timer_a_wrap;
  assign set_ev[2] = event_pin_int_mode &
                     edge_hit(pin_s2_q[2], pin_prev_q[2], event_pin_edge_sel);
  assign set_ev[1] = ext_pin1_int_mode &
                     edge_hit(pin_s2_q[1], pin_prev_q[1], edge_sel_q[BIT_PIN1_EDGE]);
  assign set_ev[0] = ext_pin0_int_mode &
                     edge_hit(pin_s2_q[0], pin_prev_q[0], edge_sel_q[BIT_PIN0_EDGE]);
  // only a written 0 clears; a written 1 leaves the flag alone
  wire  [3:0] wr_bits = {wbyte[BIT_TIMER_A_REQ], wbyte[BIT_EVENT_PIN_REQ],
                         wbyte[BIT_PIN1_REQ], wbyte[BIT_PIN0_REQ]};
  assign clr_ev = (wr_done & hit_req) ? ~wr_bits : 4'h0;
  // a set in the same cycle as a clear wins, so no edge is lost
  assign flag_d = set_ev | (flag_q & ~clr_ev);

  // read mux
  wire  [7:0] req_view = REQ_FIXED_ONES |
                         {flag_q[3], 4'h0, flag_q[2], flag_q[1], flag_q[0]};
  wire  [7:0] rd_byte  = hit_edge ? (EDGE_SEL_ONES | {6'h00, edge_sel_q}) :
                         hit_en1  ? en1_q :
                         hit_en2  ? en2_q :
                         hit_req  ? req_view : 8'h00;

  // gated requests: flag or source level and its enable
  wire  [9:0] gated_d;
  assign gated_d[9] = flag_d[3] & en1_d[BIT_TIMER_A_EN];
  assign gated_d[8] = wakeup_pins_req & en1_d[BIT_WAKEUP_EN];
  assign gated_d[7] = flag_d[2] & en1_d[BIT_EVENT_PIN_EN];
  assign gated_d[6] = flag_d[1] & en1_d[BIT_PIN1_EN];
  assign gated_d[5] = flag_d[0] & en1_d[BIT_PIN0_EN];
  assign gated_d[4] = direct_transfer_req & en2_d[BIT_DT_EN];
  assign gated_d[3] = adc_req & en2_d[BIT_ADC_EN];
  assign gated_d[2] = timer_fh_req & en2_d[BIT_TFH_EN];
  assign gated_d[1] = timer_fl_req & en2_d[BIT_TFL_EN];
  assign gated_d[0] = event_counter_req & en2_d[BIT_EC_EN];
  // the mask only blocks acceptance; flags above keep setting regardless
  wire        cpu_req_d = (|gated_d) & ~condition_code_mask;

  logic [9:0] gated_q;
  logic       cpu_req_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wait_q     <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      edge_sel_q <= EDGE_SEL_RST;
      en1_q      <= EN_RST;
      en2_q      <= EN_RST;
      flag_q     <= REQ_RST;
      gated_q    <= 10'h000;
      cpu_req_q  <= 1'b0;
    end else begin
      wait_q     <= ~(req & wait_q);
      rdata_q    <= {24'h00_0000, rd_byte};
      edge_sel_q <= edge_sel_d;
      en1_q      <= en1_d;
      en2_q      <= en2_d;
      flag_q     <= flag_d;
      gated_q    <= gated_d;
      cpu_req_q  <= cpu_req_d;
    end
  end

  assign waitrequest         = wait_q;
  assign readdata            = rdata_q;
  assign timer_a_irq         = gated_q[9];
  assign wakeup_irq          = gated_q[8];
  assign event_pin_irq       = gated_q[7];
  assign ext_pin1_irq        = gated_q[6];
  assign ext_pin0_irq        = gated_q[5];
  assign direct_transfer_irq = gated_q[4];
  assign adc_irq             = gated_q[3];
  assign timer_fh_irq        = gated_q[2];
  assign timer_fl_irq        = gated_q[1];
  assign event_counter_irq   = gated_q[0];
  assign cpu_int_req         = cpu_req_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence pin0_fall_s;
    ext_pin0_int_mode && !edge_sel_q[0] && pin_prev_q[0] && !pin_s2_q[0];
  endsequence

  sequence pin1_rise_s;
    ext_pin1_int_mode && edge_sel_q[1] && !pin_prev_q[1] && pin_s2_q[1];
  endsequence

  sequence req_write_s(logic b);
    wr_done && hit_req && (wbyte[BIT_TIMER_A_REQ] == b);
  endsequence

  bus_answer_a: assert property (req && waitrequest |=> !waitrequest)
    else $error("bus access not answered after one wait cycle");

  enable_reset_a: assert property (!$past(rst_n) |-> en1_q == 8'h00 && en2_q == 8'h00)
    else $error("enable bits not zero after reset");

  flag_hold_a: assert property (flag_q[3] && !(wr_done && hit_req) |=> flag_q[3])
    else $error("timer A flag dropped without a clearing write");

  write_one_a: assert property (req_write_s(1'b1) ##0 (!flag_q[3] && !timer_a_wrap) |=> !flag_q[3])
    else $error("writing one changed the timer A flag");

  write_zero_a: assert property (req_write_s(1'b0) ##0 !timer_a_wrap |=> !flag_q[3])
    else $error("writing zero did not clear the timer A flag");

  timer_a_set_a: assert property (timer_a_wrap |=> flag_q[3] && timer_a_irq == en1_q[BIT_TIMER_A_EN])
    else $error("timer A wrap not flagged or gated");

  fixed_one_a: assert property (read && hit_req && waitrequest |=> readdata[5])
    else $error("request register bit 5 not read as one");

  pin0_fall_a: assert property (pin0_fall_s |=> flag_q[0])
    else $error("falling edge on pin 0 not flagged");

  pin1_rise_a: assert property (pin1_rise_s |=> flag_q[1])
    else $error("rising edge on pin 1 not flagged");

  mask_block_a: assert property (condition_code_mask |=> !cpu_int_req)
    else $error("request accepted while globally masked");

  gate_off_a: assert property (!en2_d[3] |=> !timer_fh_irq)
    else $error("timer FH request passed while disabled");

  sequence pin0_rise_s;
    ext_pin0_int_mode && edge_sel_q[0] && !pin_prev_q[0] && pin_s2_q[0];
  endsequence

  sequence pin1_fall_s;
    ext_pin1_int_mode && !edge_sel_q[1] && pin_prev_q[1] && !pin_s2_q[1];
  endsequence

  sequence ev_rise_s;
    event_pin_int_mode && event_pin_edge_sel && !pin_prev_q[2] && pin_s2_q[2];
  endsequence

  sequence ev_fall_s;
    event_pin_int_mode && !event_pin_edge_sel && pin_prev_q[2] && !pin_s2_q[2];
  endsequence

  sequence en1_write_s;
    wr_done && hit_en1;
  endsequence

  sequence en2_write_s;
    wr_done && hit_en2;
  endsequence

  sequence bus_open_s;
    req && waitrequest;
  endsequence

  edge_reset_a: assert property (!$past(rst_n) |-> edge_sel_q == EDGE_SEL_RST)
    else $error("edge select not falling after reset");

  flag_reset_a: assert property (!$past(rst_n) |-> flag_q == REQ_RST && !cpu_int_req)
    else $error("request flags not clear after reset");

  pin0_rise_a: assert property (pin0_rise_s |=> flag_q[0])
    else $error("rising edge on pin 0 not flagged");

  pin1_fall_a: assert property (pin1_fall_s |=> flag_q[1])
    else $error("falling edge on pin 1 not flagged");

  ev_rise_a: assert property (ev_rise_s |=> flag_q[2])
    else $error("rising edge on event pin not flagged");

  ev_fall_a: assert property (ev_fall_s |=> flag_q[2])
    else $error("falling edge on event pin not flagged");

  pin0_mode_a: assert property (!ext_pin0_int_mode && !flag_q[0] |=> !flag_q[0])
    else $error("pin 0 flag set while not in interrupt mode");

  pin1_mode_a: assert property (!ext_pin1_int_mode && !flag_q[1] |=> !flag_q[1])
    else $error("pin 1 flag set while not in interrupt mode");

  ev_mode_a: assert property (!event_pin_int_mode && !flag_q[2] |=> !flag_q[2])
    else $error("event pin flag set while not in interrupt mode");

  flags_hold_a: assert property (!(wr_done && hit_req) |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("request flag dropped without a clearing write");

  clear_pin0_a: assert property (wr_done && hit_req && !wbyte[BIT_PIN0_REQ] && !set_ev[0] |=> !flag_q[0])
    else $error("writing zero did not clear the pin 0 flag");

  keep_pin1_a: assert property (wr_done && hit_req && wbyte[BIT_PIN1_REQ] && flag_q[1] |=> flag_q[1])
    else $error("writing one changed the pin 1 flag");

  mask_flags_a: assert property (condition_code_mask ##0 pin0_fall_s |=> flag_q[0])
    else $error("flag not set while globally masked");

  ta_gate_off_a: assert property (!en1_d[BIT_TIMER_A_EN] |=> !timer_a_irq)
    else $error("timer A request passed while disabled");

  ta_write_off_a: assert property (en1_write_s ##0 !wbyte[BIT_TIMER_A_EN] |=> !timer_a_irq)
    else $error("timer A request passed after its enable was cleared");

  ta_pass_a: assert property (timer_a_wrap && en1_q[BIT_TIMER_A_EN] && !(wr_done && hit_en1) |=> timer_a_irq)
    else $error("enabled timer A request not presented");

  wake_gate_off_a: assert property (!en1_d[BIT_WAKEUP_EN] |=> !wakeup_irq)
    else $error("wakeup request passed while disabled");

  wake_pass_a: assert property (wakeup_pins_req && en1_q[BIT_WAKEUP_EN] && !(wr_done && hit_en1) |=> wakeup_irq)
    else $error("enabled wakeup request not presented");

  ev_gate_off_a: assert property (!en1_d[BIT_EVENT_PIN_EN] |=> !event_pin_irq)
    else $error("event pin request passed while disabled");

  pin1_gate_off_a: assert property (!en1_d[BIT_PIN1_EN] |=> !ext_pin1_irq)
    else $error("pin 1 request passed while disabled");

  pin0_gate_off_a: assert property (!en1_d[BIT_PIN0_EN] |=> !ext_pin0_irq)
    else $error("pin 0 request passed while disabled");

  dt_gate_off_a: assert property (!en2_d[BIT_DT_EN] |=> !direct_transfer_irq)
    else $error("direct transfer request passed while disabled");

  dt_pass_a: assert property (direct_transfer_req && en2_q[BIT_DT_EN] && !(wr_done && hit_en2) |=> direct_transfer_irq)
    else $error("enabled direct transfer request not presented");

  adc_write_off_a: assert property (en2_write_s ##0 !wbyte[BIT_ADC_EN] |=> !adc_irq)
    else $error("converter request passed after its enable was cleared");

  adc_pass_a: assert property (adc_req && en2_q[BIT_ADC_EN] && !(wr_done && hit_en2) |=> adc_irq)
    else $error("enabled converter request not presented");

  fh_pass_a: assert property (timer_fh_req && en2_q[BIT_TFH_EN] && !(wr_done && hit_en2) |=> timer_fh_irq)
    else $error("enabled timer FH request not presented");

  fl_gate_off_a: assert property (!en2_d[BIT_TFL_EN] |=> !timer_fl_irq)
    else $error("timer FL request passed while disabled");

  fl_pass_a: assert property (timer_fl_req && en2_q[BIT_TFL_EN] && !(wr_done && hit_en2) |=> timer_fl_irq)
    else $error("enabled timer FL request not presented");

  ec_gate_off_a: assert property (!en2_d[BIT_EC_EN] |=> !event_counter_irq)
    else $error("event counter request passed while disabled");

  ec_pass_a: assert property (event_counter_req && en2_q[BIT_EC_EN] && !(wr_done && hit_en2) |=> event_counter_irq)
    else $error("enabled event counter request not presented");

  en1_reserved_a: assert property (bus_open_s ##0 (read && hit_en1) |=> (readdata[7:0] & ~EN_FIRST_IMPL) == 8'h00)
    else $error("reserved first enable bits not read as zero");

  en2_reserved_a: assert property (bus_open_s ##0 (read && hit_en2) |=> (readdata[7:0] & ~EN_SECOND_IMPL) == 8'h00)
    else $error("reserved second enable bits not read as zero");

  req_reserved_a: assert property (bus_open_s ##0 (read && hit_req) |=> !readdata[6] && readdata[4:3] == 2'h0)
    else $error("reserved request bits not read as zero");

  cpu_source_a: assert property (cpu_int_req |-> (timer_a_irq || wakeup_irq || event_pin_irq || ext_pin1_irq ||
                                 ext_pin0_irq || direct_transfer_irq || adc_irq || timer_fh_irq || timer_fl_irq || event_counter_irq))
    else $error("cpu request raised with no gated source");

endmodule

/* File: verification/interrupt_enable_request_regs_bench.sv */
// self-checking bench for the interrupt enable and request register block
`timescale 1ns/1ps
module interrupt_enable_request_regs_bench;
  import int_ctrl_pkg::*;
  logic              ref_clk, rst_n, read, write, tick, waitrequest, timer_a_wrap, cpu_req, mask;
  logic              pin0, pin1, pin_ev, mode0, mode1, mode_ev, ev_sel;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata;
  logic [5:0]        lvl;
  logic [9:0]        irq, xirq;
  logic [7:0]        e1, e2, exp_q[$];
  int                bad_count, num_checks;

  interrupt_enable_request_regs dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .ext_int_pin_zero(pin0), .ext_int_pin_one(pin1), .event_counter_int_pin(pin_ev),
    .ext_pin0_int_mode(mode0), .ext_pin1_int_mode(mode1), .event_pin_int_mode(mode_ev),
    .event_pin_edge_sel(ev_sel), .timer_a_wrap(timer_a_wrap), .wakeup_pins_req(lvl[5]),
    .direct_transfer_req(lvl[4]), .adc_req(lvl[3]), .timer_fh_req(lvl[2]), .timer_fl_req(lvl[1]),
    .event_counter_req(lvl[0]), .condition_code_mask(mask), .timer_a_irq(irq[9]), .wakeup_irq(irq[8]),
    .event_pin_irq(irq[7]), .ext_pin1_irq(irq[6]), .ext_pin0_irq(irq[5]), .direct_transfer_irq(irq[4]),
    .adc_irq(irq[3]), .timer_fh_irq(irq[2]), .timer_fl_irq(irq[1]), .event_counter_irq(irq[0]),
    .cpu_int_req(cpu_req)
  );

  timer_a_model partner (.ref_clk(ref_clk), .rst_n(rst_n), .tick(tick), .timer_a_wrap(timer_a_wrap));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until waitrequest is seen low, then lets one edge pass idle; a hang is left to the watchdog
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= {24'h0, d};
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask

  // read data is judged at the completing edge against the oldest note
  always @(posedge ref_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(readdata, {24'h0, exp_q.pop_front()});
    end
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #50000;
    bad_count++;
    tally_and_finish;
  end

  initial begin
    void'($urandom(32'hd53dc796));
    {rst_n, read, write, tick, mask, mode0, mode1, mode_ev, ev_sel} = '0;
    {pin0, pin1, pin_ev} = 3'b111;
    address = '0;
    writedata = '0;
    lvl = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_EN_FIRST, EN_RST);
    rd(ADDR_EN_SECOND, EN_RST);
    rd(ADDR_REQ_FIRST, REQ_FIXED_ONES);
    rd(ADDR_EDGE_SEL, EDGE_SEL_ONES);
    bus(1'b1, 5'h1c, 8'hff);
    rd(5'h1c, 8'h00);
    for (int i = 0; i < 8; i++) begin
      e1 = 8'($urandom) & EN_FIRST_IMPL;
      e2 = 8'($urandom) & EN_SECOND_IMPL;
      bus(1'b1, ADDR_EN_FIRST, e1);
      bus(1'b1, ADDR_EN_SECOND, e2);
      lvl  <= 6'($urandom);
      mask <= 1'($urandom);
      repeat (3) @(posedge ref_clk);
      xirq = {2'b00, 3'b000, 5'h00};
      xirq[8] = lvl[5] & e1[5];
      xirq[4:0] = lvl[4:0] & {e2[7], e2[6], e2[3], e2[2], e2[0]};
      chk({22'h0, irq}, {22'h0, xirq});
      chk({31'h0, cpu_req}, {31'h0, (|xirq) & !mask});
    end
    lvl  <= '0;
    mask <= 1'b0;
    bus(1'b1, ADDR_EN_FIRST, 8'h80);
    tick <= 1'b1;
    repeat (256) @(posedge ref_clk);
    tick <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({30'h0, irq[9], cpu_req}, 32'h3);
    rd(ADDR_REQ_FIRST, 8'ha0);
    mask <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({30'h0, irq[9], cpu_req}, 32'h2);
    bus(1'b1, ADDR_REQ_FIRST, 8'ha7);
    rd(ADDR_REQ_FIRST, 8'ha0);
    bus(1'b1, ADDR_REQ_FIRST, 8'h27);
    rd(ADDR_REQ_FIRST, 8'h20);
    {mode0, mode1, mode_ev} <= 3'b111;
    bus(1'b1, ADDR_EN_FIRST, 8'h07);
    pin0 <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(ADDR_REQ_FIRST, 8'h21);
    chk({30'h0, irq[5], cpu_req}, 32'h2);
    mask <= 1'b0;
    bus(1'b1, ADDR_EDGE_SEL, 8'h03);
    rd(ADDR_EDGE_SEL, 8'he3);
    pin1   <= 1'b0;
    ev_sel <= 1'b1;
    pin_ev <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(ADDR_REQ_FIRST, 8'h21);
    pin1   <= 1'b1;
    pin_ev <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(ADDR_REQ_FIRST, 8'h27);
    chk({29'h0, irq[7:5]}, 32'h7);
    bus(1'b1, ADDR_REQ_FIRST, 8'h00);
    mode0  <= 1'b0;
    pin0   <= 1'b1;
    ev_sel <= 1'b0;
    pin_ev <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(ADDR_REQ_FIRST, 8'h24);
    tally_and_finish;
  end
endmodule

/* File: verification/timer_a_model.sv */
// behavioural timer A counter, pulses one cycle on its wrap from ff to 00
`timescale 1ns/1ps
module timer_a_model (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic tick,
  output logic      timer_a_wrap
);
  logic [7:0] count_q;

  // counts only while ticked, so the bench knows exactly when it wraps
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_q      <= 8'h00;
      timer_a_wrap <= 1'b0;
    end else begin
      if (tick) begin
        count_q <= count_q + 8'h01;
      end
      timer_a_wrap <= tick && (count_q == 8'hff);
    end
  end
endmodule
